//--- design/ipf_bank.sv
// Purpose: Bank of four interrupt priority control registers
// Assumes: Plain register port, read data one cycle after strobe
// Notes:   Unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/1ps
`include "ipf_defs.svh"
module ipf_bank (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     srst,
    // Register port
    input  wire logic [`IPF_ADDR_W-1:0]   reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [15:0]              reg_rdata,
    // Toward arbitration
    output ipf_pkg::ipf_prio_vec_t        prio,
    output logic      [14:0]              src_enabled
);
    logic [15:0] ctrl_3;
    logic [15:0] ctrl_4;
    logic [15:0] ctrl_5;
    logic [15:0] ctrl_6;
    logic [15:0] next_rdata;

    default clocking chk_clk @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    function automatic ipf_pkg::ipf_prio_t field(input logic [15:0] r, input int pos);
        field = r[pos +: 3];
    endfunction

    ipf_prio_reg #(.MASK(`IPF_MASK_FULL), .RST_VAL(`IPF_RST_FULL)) u_ctrl_3 (
        .clk_sys (clk_sys),
        .srst    (srst),
        .we      (reg_wr && reg_addr == `IPF_OFS_CTRL_3),
        .wdata   (reg_wdata),
        .value   (ctrl_3)
    );
    ipf_prio_reg #(.MASK(`IPF_MASK_FULL), .RST_VAL(`IPF_RST_FULL)) u_ctrl_4 (
        .clk_sys (clk_sys),
        .srst    (srst),
        .we      (reg_wr && reg_addr == `IPF_OFS_CTRL_4),
        .wdata   (reg_wdata),
        .value   (ctrl_4)
    );
    // Bits 7..3 unimplemented here
    ipf_prio_reg #(.MASK(`IPF_MASK_CTRL_5), .RST_VAL(`IPF_RST_CTRL_5)) u_ctrl_5 (
        .clk_sys (clk_sys),
        .srst    (srst),
        .we      (reg_wr && reg_addr == `IPF_OFS_CTRL_5),
        .wdata   (reg_wdata),
        .value   (ctrl_5)
    );
    ipf_prio_reg #(.MASK(`IPF_MASK_FULL), .RST_VAL(`IPF_RST_FULL)) u_ctrl_6 (
        .clk_sys (clk_sys),
        .srst    (srst),
        .we      (reg_wr && reg_addr == `IPF_OFS_CTRL_6),
        .wdata   (reg_wdata),
        .value   (ctrl_6)
    );

    always_comb begin
        case (reg_addr)
            `IPF_OFS_CTRL_3: next_rdata = ctrl_3;
            `IPF_OFS_CTRL_4: next_rdata = ctrl_4;
            `IPF_OFS_CTRL_5: next_rdata = ctrl_5;
            `IPF_OFS_CTRL_6: next_rdata = ctrl_6;
            default:         next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Field placement, registered so every output is a flop
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prio <= {15{`IPF_PRIO_RST}};
        end else begin
            prio.flash_ctrl_prio    <= field(ctrl_3, `IPF_POS_HI);
            prio.dma_ch1_prio       <= field(ctrl_3, `IPF_POS_MH);
            prio.adc_prio           <= field(ctrl_3, `IPF_POS_ML);
            prio.uart1_tx_prio      <= field(ctrl_3, `IPF_POS_LO);
            prio.change_notify_prio <= field(ctrl_4, `IPF_POS_HI);
            prio.comparator_prio    <= field(ctrl_4, `IPF_POS_MH);
            prio.i2c1_master_prio   <= field(ctrl_4, `IPF_POS_ML);
            prio.i2c1_slave_prio    <= field(ctrl_4, `IPF_POS_LO);
            prio.capcomp6_prio      <= field(ctrl_5, `IPF_POS_HI);
            prio.capcomp5_prio      <= field(ctrl_5, `IPF_POS_MH);
            prio.ext_irq1_prio      <= field(ctrl_5, `IPF_POS_LO);
            prio.timer4_prio        <= field(ctrl_6, `IPF_POS_HI);
            prio.outcmp4_prio       <= field(ctrl_6, `IPF_POS_MH);
            prio.outcmp3_prio       <= field(ctrl_6, `IPF_POS_ML);
            prio.dma_ch2_prio       <= field(ctrl_6, `IPF_POS_LO);
        end
    end

    // Level 7 highest, 1 lowest, 0 means source off
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            src_enabled <= `IPF_EN_RST;
        end else begin
            for (int i = 0; i < 15; i++) begin
                src_enabled[i] <= field(ctrl_of(i), pos_of(i)) != `IPF_PRIO_OFF;
            end
        end
    end

    // Source index 14 is flash, 0 is dma channel 2, matching prio packing
    function automatic logic [15:0] ctrl_of(input int i);
        if (i >= 11) begin
            ctrl_of = ctrl_3;
        end else if (i >= 7) begin
            ctrl_of = ctrl_4;
        end else if (i >= 4) begin
            ctrl_of = ctrl_5;
        end else begin
            ctrl_of = ctrl_6;
        end
    endfunction

    function automatic int pos_of(input int i);
        if (i >= 11) begin
            pos_of = 4 * (i - 11);
        end else if (i >= 7) begin
            pos_of = 4 * (i - 7);
        end else if (i >= 4) begin
            pos_of = (i == 4) ? 0 : 4 * (i - 3);
        end else begin
            pos_of = 4 * i;
        end
    endfunction

    // Checks
    // Reset state
    rst_prio4_a: assert property (
        $fell(srst) |-> ctrl_3 == `IPF_RST_FULL && ctrl_6 == `IPF_RST_FULL)
        else $error("reset value wrong");
    rst_fields_a: assert property (
        $fell(srst) |-> ctrl_4 == `IPF_RST_FULL && ctrl_5 == `IPF_RST_CTRL_5)
        else $error("reset value wrong in ctrl 4 or 5");
    rst_outputs_a: assert property (
        $fell(srst) |-> prio == {15{`IPF_PRIO_RST}} && src_enabled == `IPF_EN_RST)
        else $error("reset outputs wrong");

    // Register port reads
    rd_unmapped_a: assert property (
        reg_rd && reg_addr > `IPF_OFS_CTRL_6 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    rd_low_a: assert property (
        reg_rd && reg_addr < `IPF_OFS_CTRL_3 |=> reg_rdata == 16'h0000)
        else $error("low unmapped read not zero");
    rd_idle_a: assert property (
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    rd_ctrl3_a: assert property (
        reg_rd && reg_addr == `IPF_OFS_CTRL_3 |=> reg_rdata == $past(ctrl_3))
        else $error("ctrl 3 read wrong");
    rd_ctrl4_a: assert property (
        reg_rd && reg_addr == `IPF_OFS_CTRL_4 |=> reg_rdata == $past(ctrl_4))
        else $error("ctrl 4 read wrong");
    rd_ctrl5_a: assert property (
        reg_rd && reg_addr == `IPF_OFS_CTRL_5 |=> reg_rdata == $past(ctrl_5))
        else $error("ctrl 5 read wrong");
    rd_ctrl6_a: assert property (
        reg_rd && reg_addr == `IPF_OFS_CTRL_6 |=> reg_rdata == $past(ctrl_6))
        else $error("ctrl 6 read wrong");

    // Writes land masked, other words hold
    wr_readback_a: assert property (
        reg_wr && reg_addr == `IPF_OFS_CTRL_3 ##1 reg_rd && reg_addr == `IPF_OFS_CTRL_3
        && !reg_wr |=> reg_rdata == ($past(reg_wdata, 2) & `IPF_MASK_FULL))
        else $error("write not read back");
    wr_ctrl3_a: assert property (
        reg_wr && reg_addr == `IPF_OFS_CTRL_3 |=> ctrl_3 == ($past(reg_wdata) & `IPF_MASK_FULL))
        else $error("ctrl 3 write wrong");
    wr_ctrl4_a: assert property (
        reg_wr && reg_addr == `IPF_OFS_CTRL_4 |=> ctrl_4 == ($past(reg_wdata) & `IPF_MASK_FULL))
        else $error("ctrl 4 write wrong");
    wr_ctrl5_a: assert property (
        reg_wr && reg_addr == `IPF_OFS_CTRL_5 |=> ctrl_5 == ($past(reg_wdata) & `IPF_MASK_CTRL_5))
        else $error("ctrl 5 write wrong");
    wr_ctrl6_a: assert property (
        reg_wr && reg_addr == `IPF_OFS_CTRL_6 |=> ctrl_6 == ($past(reg_wdata) & `IPF_MASK_FULL))
        else $error("ctrl 6 write wrong");
    hold_ctrl3_a: assert property (
        !(reg_wr && reg_addr == `IPF_OFS_CTRL_3) |=> $stable(ctrl_3))
        else $error("ctrl 3 changed without write");
    hold_ctrl4_a: assert property (
        !(reg_wr && reg_addr == `IPF_OFS_CTRL_4) |=> $stable(ctrl_4))
        else $error("ctrl 4 changed without write");
    hold_ctrl5_a: assert property (
        !(reg_wr && reg_addr == `IPF_OFS_CTRL_5) |=> $stable(ctrl_5))
        else $error("ctrl 5 changed without write");
    hold_ctrl6_a: assert property (
        !(reg_wr && reg_addr == `IPF_OFS_CTRL_6) |=> $stable(ctrl_6))
        else $error("ctrl 6 changed without write");
    rsvd_zero_a: assert property (
        (ctrl_5 & ~`IPF_MASK_CTRL_5) == 16'h0000)
        else $error("reserved bits set in ctrl 5");
    rsvd_ctrl3_a: assert property (
        (ctrl_3 & ~`IPF_MASK_FULL) == 16'h0000)
        else $error("reserved bits set in ctrl 3");
    rsvd_ctrl4_a: assert property (
        (ctrl_4 & ~`IPF_MASK_FULL) == 16'h0000)
        else $error("reserved bits set in ctrl 4");
    rsvd_ctrl6_a: assert property (
        (ctrl_6 & ~`IPF_MASK_FULL) == 16'h0000)
        else $error("reserved bits set in ctrl 6");

    // Field placement toward arbitration
    flash_map_a: assert property (
        reg_wr && reg_addr == `IPF_OFS_CTRL_3 ##1 !reg_wr |=>
        prio.flash_ctrl_prio == $past(reg_wdata[14:12], 2))
        else $error("flash priority misplaced");
    dma1_map_a: assert property (
        ##1 prio.dma_ch1_prio == $past(ctrl_3[10:8]))
        else $error("dma1 priority misplaced");
    adc_map_a: assert property (
        ##1 prio.adc_prio == $past(ctrl_3[6:4]))
        else $error("adc priority misplaced");
    utx_map_a: assert property (
        ##1 prio.uart1_tx_prio == $past(ctrl_3[2:0]))
        else $error("uart1 tx priority misplaced");
    chg_map_a: assert property (
        ##1 prio.change_notify_prio == $past(ctrl_4[14:12]))
        else $error("change notify priority misplaced");
    cmp_map_a: assert property (
        ##1 prio.comparator_prio == $past(ctrl_4[10:8]))
        else $error("comparator priority misplaced");
    i2cm_map_a: assert property (
        ##1 prio.i2c1_master_prio == $past(ctrl_4[6:4]))
        else $error("i2c1 master priority misplaced");
    i2cs_map_a: assert property (
        ##1 prio.i2c1_slave_prio == $past(ctrl_4[2:0]))
        else $error("i2c1 slave priority misplaced");
    cap6_map_a: assert property (
        ##1 prio.capcomp6_prio == $past(ctrl_5[14:12]))
        else $error("capcomp6 priority misplaced");
    cap5_map_a: assert property (
        ##1 prio.capcomp5_prio == $past(ctrl_5[10:8]))
        else $error("capcomp5 priority misplaced");
    ext1_map_a: assert property (
        ##1 prio.ext_irq1_prio == $past(ctrl_5[2:0]))
        else $error("ext irq1 priority misplaced");
    tmr4_map_a: assert property (
        ##1 prio.timer4_prio == $past(ctrl_6[14:12]))
        else $error("timer4 priority misplaced");
    ocmp4_map_a: assert property (
        ##1 prio.outcmp4_prio == $past(ctrl_6[10:8]))
        else $error("outcmp4 priority misplaced");
    ocmp3_map_a: assert property (
        ##1 prio.outcmp3_prio == $past(ctrl_6[6:4]))
        else $error("outcmp3 priority misplaced");
    dma2_map_a: assert property (
        ##1 prio.dma_ch2_prio == $past(ctrl_6[2:0]))
        else $error("dma2 priority misplaced");

    // Level codes and per-source enables
    off_code_a: assert property (
        ##1 src_enabled[0] == ($past(ctrl_6[2:0]) != `IPF_PRIO_OFF))
        else $error("disable code not honoured");
    top_code_a: assert property (
        ##1 $past(ctrl_3[14:12]) == 3'h7 |-> src_enabled[14]
        && prio.flash_ctrl_prio == 3'h7)
        else $error("top level not enabled");
    en_flash_a: assert property (
        ##1 src_enabled[14] == ($past(ctrl_3[14:12]) != `IPF_PRIO_OFF))
        else $error("flash enable wrong");
    en_dma1_a: assert property (
        ##1 src_enabled[13] == ($past(ctrl_3[10:8]) != `IPF_PRIO_OFF))
        else $error("dma1 enable wrong");
    en_adc_a: assert property (
        ##1 src_enabled[12] == ($past(ctrl_3[6:4]) != `IPF_PRIO_OFF))
        else $error("adc enable wrong");
    en_utx_a: assert property (
        ##1 src_enabled[11] == ($past(ctrl_3[2:0]) != `IPF_PRIO_OFF))
        else $error("uart1 tx enable wrong");
    en_chg_a: assert property (
        ##1 src_enabled[10] == ($past(ctrl_4[14:12]) != `IPF_PRIO_OFF))
        else $error("change notify enable wrong");
    en_cmp_a: assert property (
        ##1 src_enabled[9] == ($past(ctrl_4[10:8]) != `IPF_PRIO_OFF))
        else $error("comparator enable wrong");
    en_i2cm_a: assert property (
        ##1 src_enabled[8] == ($past(ctrl_4[6:4]) != `IPF_PRIO_OFF))
        else $error("i2c1 master enable wrong");
    en_i2cs_a: assert property (
        ##1 src_enabled[7] == ($past(ctrl_4[2:0]) != `IPF_PRIO_OFF))
        else $error("i2c1 slave enable wrong");
    en_cap6_a: assert property (
        ##1 src_enabled[6] == ($past(ctrl_5[14:12]) != `IPF_PRIO_OFF))
        else $error("capcomp6 enable wrong");
    en_cap5_a: assert property (
        ##1 src_enabled[5] == ($past(ctrl_5[10:8]) != `IPF_PRIO_OFF))
        else $error("capcomp5 enable wrong");
    en_ext1_a: assert property (
        ##1 src_enabled[4] == ($past(ctrl_5[2:0]) != `IPF_PRIO_OFF))
        else $error("ext irq1 enable wrong");
    en_tmr4_a: assert property (
        ##1 src_enabled[3] == ($past(ctrl_6[14:12]) != `IPF_PRIO_OFF))
        else $error("timer4 enable wrong");
    en_ocmp4_a: assert property (
        ##1 src_enabled[2] == ($past(ctrl_6[10:8]) != `IPF_PRIO_OFF))
        else $error("outcmp4 enable wrong");
    en_ocmp3_a: assert property (
        ##1 src_enabled[1] == ($past(ctrl_6[6:4]) != `IPF_PRIO_OFF))
        else $error("outcmp3 enable wrong");

    // Enables agree with presented levels
    agree_flash_a: assert property (
        src_enabled[14] == (prio.flash_ctrl_prio != `IPF_PRIO_OFF))
        else $error("flash enable and level disagree");
    agree_dma1_a: assert property (
        src_enabled[13] == (prio.dma_ch1_prio != `IPF_PRIO_OFF))
        else $error("dma1 enable and level disagree");
    agree_adc_a: assert property (
        src_enabled[12] == (prio.adc_prio != `IPF_PRIO_OFF))
        else $error("adc enable and level disagree");
    agree_utx_a: assert property (
        src_enabled[11] == (prio.uart1_tx_prio != `IPF_PRIO_OFF))
        else $error("uart1 tx enable and level disagree");
    agree_chg_a: assert property (
        src_enabled[10] == (prio.change_notify_prio != `IPF_PRIO_OFF))
        else $error("change notify enable and level disagree");
    agree_cmp_a: assert property (
        src_enabled[9] == (prio.comparator_prio != `IPF_PRIO_OFF))
        else $error("comparator enable and level disagree");
    agree_i2cm_a: assert property (
        src_enabled[8] == (prio.i2c1_master_prio != `IPF_PRIO_OFF))
        else $error("i2c1 master enable and level disagree");
    agree_i2cs_a: assert property (
        src_enabled[7] == (prio.i2c1_slave_prio != `IPF_PRIO_OFF))
        else $error("i2c1 slave enable and level disagree");
    agree_cap6_a: assert property (
        src_enabled[6] == (prio.capcomp6_prio != `IPF_PRIO_OFF))
        else $error("capcomp6 enable and level disagree");
    agree_cap5_a: assert property (
        src_enabled[5] == (prio.capcomp5_prio != `IPF_PRIO_OFF))
        else $error("capcomp5 enable and level disagree");
    agree_ext1_a: assert property (
        src_enabled[4] == (prio.ext_irq1_prio != `IPF_PRIO_OFF))
        else $error("ext irq1 enable and level disagree");
    agree_tmr4_a: assert property (
        src_enabled[3] == (prio.timer4_prio != `IPF_PRIO_OFF))
        else $error("timer4 enable and level disagree");
    agree_ocmp4_a: assert property (
        src_enabled[2] == (prio.outcmp4_prio != `IPF_PRIO_OFF))
        else $error("outcmp4 enable and level disagree");
    agree_ocmp3_a: assert property (
        src_enabled[1] == (prio.outcmp3_prio != `IPF_PRIO_OFF))
        else $error("outcmp3 enable and level disagree");
    agree_dma2_a: assert property (
        src_enabled[0] == (prio.dma_ch2_prio != `IPF_PRIO_OFF))
        else $error("dma2 enable and level disagree");
endmodule

//--- design/ipf_defs.svh
// Purpose: Constants for the interrupt priority field bank
// Assumes: 16-bit registers, word index addressing on a plain port
// Notes:   Offsets are register indexes on the address port
`ifndef IPF_DEFS_SVH
`define IPF_DEFS_SVH
`define IPF_ADDR_W      4
`define IPF_OFS_CTRL_3  4'h3
`define IPF_OFS_CTRL_4  4'h4
`define IPF_OFS_CTRL_5  4'h5
`define IPF_OFS_CTRL_6  4'h6
`define IPF_POS_HI      12
`define IPF_POS_MH      8
`define IPF_POS_ML      4
`define IPF_POS_LO      0
`define IPF_PRIO_RST    3'h4
`define IPF_PRIO_OFF    3'h0
`define IPF_MASK_FULL   16'h7777
`define IPF_MASK_CTRL_5 16'h7707
`define IPF_RST_FULL    16'h4444
`define IPF_RST_CTRL_5  16'h4404
`define IPF_EN_RST      15'h7fff
`endif

//--- design/ipf_pkg.sv
// Purpose: Types for the interrupt priority field bank
// Assumes: Constants come from ipf_defs.svh
// Notes:   Priority vector groups all fifteen sources
package ipf_pkg;
    typedef logic [2:0] ipf_prio_t;
    typedef struct packed {
        ipf_prio_t flash_ctrl_prio;
        ipf_prio_t dma_ch1_prio;
        ipf_prio_t adc_prio;
        ipf_prio_t uart1_tx_prio;
        ipf_prio_t change_notify_prio;
        ipf_prio_t comparator_prio;
        ipf_prio_t i2c1_master_prio;
        ipf_prio_t i2c1_slave_prio;
        ipf_prio_t capcomp6_prio;
        ipf_prio_t capcomp5_prio;
        ipf_prio_t ext_irq1_prio;
        ipf_prio_t timer4_prio;
        ipf_prio_t outcmp4_prio;
        ipf_prio_t outcmp3_prio;
        ipf_prio_t dma_ch2_prio;
    } ipf_prio_vec_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } ipf_bus_req_t;
endpackage

//--- design/ipf_prio_reg.sv
// Purpose: One 16-bit priority register with implemented-bit mask
// Assumes: Same clock and reset as the bank
// Notes:   Masked bits are constant zero
`timescale 1ns/1ps
`include "ipf_defs.svh"
module ipf_prio_reg #(
    parameter logic [15:0] MASK    = `IPF_MASK_FULL,
    parameter logic [15:0] RST_VAL = `IPF_RST_FULL
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Write side
    input  wire logic        we,
    input  wire logic [15:0] wdata,
    // Stored value
    output logic      [15:0] value
);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            value <= RST_VAL;
        end else if (we) begin
            value <= wdata & MASK;
        end
    end
endmodule

//--- sim/ipf_tb.sv
// Purpose: Self-checking bench for the interrupt priority field bank
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Bench drives every input itself; fixed waits follow the port timing
`timescale 1ns/1ps
`include "ipf_defs.svh"
module tb;
    logic                   clk_sys;
    logic                   srst;
    logic [`IPF_ADDR_W-1:0] reg_addr;
    logic [15:0]            reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [15:0]            reg_rdata;
    ipf_pkg::ipf_prio_vec_t prio;
    logic [14:0]            src_enabled;
    ipf_pkg::ipf_prio_vec_t exp_prio;
    logic [15:0]            rd_val;
    int                     n_fail;
    int                     tests_run;

    ipf_bank ipf_bank_i (
        .clk_sys     (clk_sys),
        .srst        (srst),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .prio        (prio),
        .src_enabled (src_enabled)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [44:0] seen, input logic [44:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Called at a rising edge; returns one edge after the strobe drops
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Read data taken at the edge that closes the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(posedge clk_sys);
        v = reg_rdata;
    endtask

    // Power-on contents, priorities and enables
    task automatic t_reset();
        for (int i = 3; i <= 6; i++) begin
            rd_reg(4'(i), rd_val);
            chk(45'(rd_val), 45'(i == 5 ? `IPF_RST_CTRL_5 : `IPF_RST_FULL), "reset");
        end
        chk(prio, {15{`IPF_PRIO_RST}}, "reset prio");
        chk(45'(src_enabled), 45'(`IPF_EN_RST), "reset enables");
    endtask

    // All ones: only implemented bits stick, every field at the top level
    task automatic t_ones();
        for (int i = 3; i <= 6; i++) begin
            wr_reg(4'(i), 16'hFFFF);
            rd_reg(4'(i), rd_val);
            chk(45'(rd_val), 45'(i == 5 ? `IPF_MASK_CTRL_5 : `IPF_MASK_FULL), "mask");
        end
        chk(prio, {15{3'h7}}, "top prio");
    endtask

    // Distinct codes per field, zero codes disable, next-edge visibility
    task automatic t_map();
        wr_reg(`IPF_OFS_CTRL_3, 16'h7123);
        wr_reg(`IPF_OFS_CTRL_4, 16'h4567);
        wr_reg(`IPF_OFS_CTRL_5, 16'h90FA);
        wr_reg(`IPF_OFS_CTRL_6, 16'h3210);
        @(posedge clk_sys);
        exp_prio = {3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7,
                    3'h1, 3'h0, 3'h2, 3'h3, 3'h2, 3'h1, 3'h0};
        chk(prio, exp_prio, "field map");
        chk(45'(prio.adc_prio), 45'h2, "adc field");
        chk(45'(src_enabled), 45'h7FDE, "enables");
        rd_reg(`IPF_OFS_CTRL_5, rd_val);
        chk(45'(rd_val), 45'h1002, "ctrl5 readback");
    endtask

    // Unmapped indexes read zero and disturb nothing
    task automatic t_unmapped();
        wr_reg(4'h7, 16'hFFFF);
        wr_reg(4'h2, 16'h0000);
        rd_reg(4'h7, rd_val);
        chk(45'(rd_val), 45'h0, "unmapped read");
        rd_reg(4'h2, rd_val);
        chk(45'(rd_val), 45'h0, "low unmapped read");
        rd_reg(`IPF_OFS_CTRL_3, rd_val);
        chk(45'(rd_val), 45'h7123, "ctrl3 kept");
        chk(prio, exp_prio, "prio kept");
    endtask

    // Write then read with no gap; read data stands one cycle only
    task automatic t_b2b();
        reg_addr  <= `IPF_OFS_CTRL_3;
        reg_wdata <= 16'h5A3C;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk_sys);
        reg_rd    <= 1'b0;
        @(posedge clk_sys);
        chk(45'(reg_rdata), 45'h5234, "b2b readback");
        @(posedge clk_sys);
        chk(45'(reg_rdata), 45'h0, "rdata after read");
        chk(45'(prio.flash_ctrl_prio), 45'h5, "b2b flash level");
    endtask

    // Reset in mid-run restores power-on state
    task automatic t_rerun();
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
    endtask

    initial begin
        n_fail    = 0;
        tests_run = 0;
        srst      = 1'b1;
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
        t_ones();
        t_map();
        t_unmapped();
        t_b2b();
        t_rerun();
        final_report();
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        final_report();
    end
endmodule
